/* File: common/ovl_cmd_pkg.sv */
// Constants for the overlay command handler: opcodes, parameter offsets,
// result codes, attribute identifiers and the frame-timing figures.
// Assumes a host that writes a parameter pool and an opcode over a plain port.
package ovl_cmd_pkg;
  // ----------------------------------------
  // Register offsets (register index = byte offset / 4 is not used here).
  // ----------------------------------------
  localparam logic [3:0] REG_OPCODE = 4'h0;
  localparam logic [3:0] REG_PARAM = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_RESP = 4'h3;
  localparam logic [3:0] REG_SHIFT_OUT = 4'h4;
  localparam logic [3:0] REG_BITMAP_BASE = 4'h8;
  // ----------------------------------------
  // Opcodes.
  // ----------------------------------------
  localparam logic [15:0] OP_POWER = 16'h8200;
  localparam logic [15:0] OP_STATE = 16'h8201;
  localparam logic [15:0] OP_SHIFT = 16'h8202;
  localparam logic [15:0] OP_BM_WRITE = 16'h8203;
  localparam logic [15:0] OP_BM_READ = 16'h8204;
  localparam logic [15:0] OP_TEXT0 = 16'h8205;
  localparam logic [15:0] OP_TEXT1 = 16'h8215;
  localparam logic [15:0] OP_TEXT2 = 16'h8216;
  localparam logic [15:0] OP_TEXT3 = 16'h8217;
  // ----------------------------------------
  // Result codes.
  // ----------------------------------------
  localparam logic [7:0] RES_ENOERR = 8'h00;
  localparam logic [7:0] RES_ENOENT = 8'h02;
  localparam logic [7:0] RES_EIO = 8'h05;
  localparam logic [7:0] RES_EACCES = 8'h0d;
  localparam logic [7:0] RES_EBUSY = 8'h10;
  localparam logic [7:0] RES_EINVAL = 8'h16;
  localparam logic [7:0] RES_ERANGE = 8'h22;
  localparam logic [7:0] RES_EALREADY = 8'h45;
  localparam logic [7:0] RES_PENDING = 8'hff;
  // ----------------------------------------
  // Attribute identifiers and limits.
  // ----------------------------------------
  localparam logic [7:0] ATTR_WIDTH = 8'h02;
  localparam logic [7:0] ATTR_APPLY_SHIFT = 8'h05;
  localparam logic [7:0] ATTR_EXPIRY = 8'h0f;
  localparam logic [7:0] ATTR_LAST = 8'h32;
  localparam logic [7:0] NUM_BUFFERS = 8'h07;
  localparam logic [7:0] SHIFT_MAX_DEFAULT = 8'h3f;
  localparam int EXPIRY_UNIT_FRAMES = 5;
  localparam logic [2:0] EXPIRY_UNIT = 3'h5;
endpackage : ovl_cmd_pkg

/* File: logic/ovl_cmd_handler.sv */
// Overlay command interpreter: decodes host opcodes, checks parameters,
// stores bitmap attributes and applies updates at frame edges and blanking.
// Assumes frame start and blanking come in as pins from the video timing.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
module ovl_cmd_handler
  import ovl_cmd_pkg::*;
#(
  parameter logic [7:0] SHIFT_MAX = SHIFT_MAX_DEFAULT
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_resetn,
  // Register port.
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Video timing pins.
  input wire logic i_frame_start,
  input wire logic i_blank,
  // Overlay hardware side.
  input wire logic [7:0] i_fault_code,
  input wire logic [6:0] i_buf_loaded,
  input wire logic [6:0] i_buf_shown,
  output logic o_overlay_on,
  output logic [7:0] o_shift_x,
  output logic [7:0] o_shift_y,
  output logic [6:0] o_shift_apply,
  output logic [6:0] o_expired,
  output logic o_text_wr,
  output logic [1:0] o_text_sel,
  output logic [7:0] o_text_attr,
  output logic [15:0] o_text_value
);
  if (SHIFT_MAX == 8'h00) begin : g_bad_shift_max
    $error("SHIFT_MAX must be nonzero");
  end
  // ----------------------------------------
  // Input synchronisers.
  // ----------------------------------------
  logic [1:0] fs_meta, bl_meta;
  logic fs_q;
  wire fs_rise = fs_meta[1] & ~fs_q;
  wire blank = bl_meta[1];
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fs_meta <= 2'h0;
      bl_meta <= 2'h0;
      fs_q <= 1'b0;
    end else begin
      fs_meta <= {fs_meta[0], i_frame_start};
      bl_meta <= {bl_meta[0], i_blank};
      fs_q <= fs_meta[1];
    end
  end
  // ----------------------------------------
  // Command intake and decode.
  // ----------------------------------------
  logic [15:0] opcode;
  logic [31:0] p0, p1;
  logic cmd_go;
  logic [7:0] status;
  logic [31:0] resp;
  wire wr_op = i_wr && i_addr == REG_OPCODE;
  wire [7:0] bidx = p0[7:0];
  wire [7:0] attr = p0[15:8];
  wire [15:0] val = p1[15:0];
  wire bidx_ok = bidx < NUM_BUFFERS;
  wire [2:0] bi = bidx[2:0];
  wire attr_ok = attr <= ATTR_LAST;
  wire is_text = opcode == OP_TEXT0 || opcode == OP_TEXT1 ||
                 opcode == OP_TEXT2 || opcode == OP_TEXT3;
  // ----------------------------------------
  // Subsystem state.
  // ----------------------------------------
  logic power_req, power_pend;
  logic [7:0] fault;
  logic [7:0] shx_pend, shy_pend;
  logic shift_pend;
  logic frame_used;
  logic [6:0] apply_flag;
  logic [7:0] remain [7];
  logic [2:0] sub5 [7];
  logic [15:0] attr_mem [7][64];
  function automatic logic [1:0] text_index(input logic [15:0] op);
    case (op)
      OP_TEXT1: text_index = 2'h1;
      OP_TEXT2: text_index = 2'h2;
      OP_TEXT3: text_index = 2'h3;
      default: text_index = 2'h0;
    endcase
  endfunction : text_index
  // Write-side verdict for an attribute write, combinational.
  logic [7:0] bm_res;
  always_comb begin
    if (!attr_ok || !bidx_ok) bm_res = RES_EINVAL;
    else if (!i_buf_loaded[bi]) bm_res = RES_ENOENT;
    else if (attr == ATTR_WIDTH) bm_res = RES_EACCES;
    else if (attr == ATTR_APPLY_SHIFT && val > 16'h0001) bm_res = RES_ERANGE;
    else if (attr == ATTR_EXPIRY && val > 16'h00ff) bm_res = RES_ERANGE;
    else if (i_buf_shown[bi] && frame_used) bm_res = RES_EBUSY;
    else bm_res = RES_ENOERR;
  end
  wire bm_ok = bm_res == RES_ENOERR;
  // Frames left before expiry: whole units still to run, less the frames of this unit gone.
  wire [10:0] bi_left = 11'(remain[bi]) * 11'(EXPIRY_UNIT) - 11'(sub5[bi]);
  wire shift_ok = p0[7:0] <= SHIFT_MAX && p0[15:8] <= SHIFT_MAX;
  // Blanking-timed apply of a displayed bitmap update; the previous value
  // stays visible to reads until then, which is why reads may look stale.
  logic shown_pend;
  logic [2:0] shown_bi;
  logic [5:0] shown_attr;
  logic [15:0] shown_val;
  // ----------------------------------------
  // Command execution, one per opcode write taken while no command is pending.
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      opcode <= 16'h0000;
      p0 <= 32'h0;
      p1 <= 32'h0;
      cmd_go <= 1'b0;
      status <= RES_ENOERR;
      resp <= 32'h0;
      power_req <= 1'b0;
      power_pend <= 1'b0;
      shx_pend <= 8'h00;
      shy_pend <= 8'h00;
      shift_pend <= 1'b0;
      shown_pend <= 1'b0;
      shown_bi <= 3'h0;
      shown_attr <= 6'h00;
      shown_val <= 16'h0000;
      o_text_wr <= 1'b0;
      o_text_sel <= 2'h0;
      o_text_attr <= 8'h00;
      o_text_value <= 16'h0000;
    end else begin
      o_text_wr <= 1'b0;
      cmd_go <= 1'b0;
      if (i_wr && i_addr == REG_PARAM) p0 <= i_wdata;
      if (i_wr && i_addr == REG_PARAM + 4'h1) p1 <= i_wdata;
      if (wr_op && status != RES_PENDING) begin
        opcode <= i_wdata[15:0];
        cmd_go <= 1'b1;
        status <= RES_PENDING;
      end
      // Clears come first so that a new shift or shown request in the same cycle is kept; a power request in that cycle still gets EBUSY.
      if (power_pend && fs_rise) power_pend <= 1'b0;
      if (shift_pend && blank) shift_pend <= 1'b0;
      if (shown_pend && blank) shown_pend <= 1'b0;
      if (cmd_go) begin
        resp <= 32'h0;
        status <= RES_ENOERR;
        case (opcode)
          OP_POWER: begin
            if (power_pend) status <= RES_EBUSY;
            else if (p0[0] && o_overlay_on) status <= RES_EALREADY;
            else begin
              power_req <= p0[0];
              power_pend <= 1'b1;
            end
          end
          OP_STATE: resp <= {fault, 16'h0000, 7'h00, o_overlay_on};
          OP_SHIFT: begin
            if (!shift_ok) status <= RES_ERANGE;
            else begin
              shx_pend <= p0[7:0];
              shy_pend <= p0[15:8];
              shift_pend <= 1'b1;
            end
          end
          OP_BM_WRITE: begin
            status <= bm_res;
            if (bm_ok && i_buf_shown[bi]) begin
              shown_pend <= 1'b1;
              shown_bi <= bi;
              shown_attr <= attr[5:0];
              shown_val <= val;
            end
          end
          OP_BM_READ: begin
            if (!attr_ok || !bidx_ok) status <= RES_EINVAL;
            else if (!i_buf_loaded[bi]) status <= RES_ENOENT;
            else if (attr == ATTR_EXPIRY) resp <= {21'h0, bi_left};
            else resp <= {16'h0, attr_mem[bi][attr[5:0]]};
          end
          default: begin
            if (is_text) begin
              if (p0[7:0] > ATTR_LAST) status <= RES_EINVAL;
              else begin
                o_text_wr <= 1'b1;
                o_text_sel <= text_index(opcode);
                o_text_attr <= p0[7:0];
                o_text_value <= val;
              end
            end else status <= RES_EINVAL;
          end
        endcase
      end
    end
  end
  // ----------------------------------------
  // Frame-timed outputs and attribute storage.
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_overlay_on <= 1'b0;
      o_shift_x <= 8'h00;
      o_shift_y <= 8'h00;
      frame_used <= 1'b0;
      fault <= RES_ENOERR;
    end else begin
      if (fault == RES_ENOERR) fault <= i_fault_code;
      if (power_pend && fs_rise) o_overlay_on <= power_req;
      if (shift_pend && blank) begin
        o_shift_x <= shx_pend;
        o_shift_y <= shy_pend;
      end
      if (fs_rise) frame_used <= 1'b0;
      if (cmd_go && opcode == OP_BM_WRITE && bm_ok && i_buf_shown[bi])
        frame_used <= 1'b1;
    end
  end
  wire hidden_wr = cmd_go && opcode == OP_BM_WRITE && bm_ok && !i_buf_shown[bi];
  always_ff @(posedge i_clk) begin
    if (hidden_wr) attr_mem[bi][attr[5:0]] <= val;
    if (shown_pend && blank) attr_mem[shown_bi][shown_attr] <= shown_val;
  end
  // Expiry countdown per buffer, one 5-frame unit per step.
  for (genvar g = 0; g < 7; g++) begin : g_buf
    wire set_here = (hidden_wr && bi == g && attr == ATTR_EXPIRY) ||
                    (shown_pend && blank && shown_bi == g && shown_attr == ATTR_EXPIRY[5:0]);
    wire [7:0] set_val = hidden_wr ? val[7:0] : shown_val[7:0];
    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        apply_flag[g] <= 1'b0;
        remain[g] <= 8'h00;
        sub5[g] <= 3'h0;
        o_expired[g] <= 1'b0;
      end else begin
        o_expired[g] <= 1'b0;
        if (set_here) begin
          remain[g] <= set_val;
          sub5[g] <= 3'h0;
        end else if (fs_rise && remain[g] != 8'h00) begin
          if (sub5[g] == EXPIRY_UNIT - 3'h1) begin
            sub5[g] <= 3'h0;
            remain[g] <= remain[g] - 8'h01;
            if (remain[g] == 8'h01) o_expired[g] <= 1'b1;
          end else sub5[g] <= sub5[g] + 3'h1;
        end
        if ((hidden_wr && bi == g && attr == ATTR_APPLY_SHIFT) ||
            (shown_pend && blank && shown_bi == g &&
             shown_attr == ATTR_APPLY_SHIFT[5:0]))
          apply_flag[g] <= hidden_wr ? val[0] : shown_val[0];
      end
    end
  end
  assign o_shift_apply = apply_flag;
  // ----------------------------------------
  // Register read port.
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) o_rdata <= 32'h0;
    else if (i_rd) begin
      case (i_addr)
        REG_OPCODE: o_rdata <= {16'h0, opcode};
        REG_PARAM: o_rdata <= p0;
        REG_STATUS: o_rdata <= {24'h0, status};
        REG_RESP: o_rdata <= resp;
        REG_SHIFT_OUT: o_rdata <= {16'h0, o_shift_y, o_shift_x};
        default: o_rdata <= 32'h0;
      endcase
    end else o_rdata <= 32'h0;
  end
  // ----------------------------------------
  // Checks.
  // ----------------------------------------
  AST_POWER_FRAME: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $changed(o_overlay_on) |-> $past(fs_rise)) else $error("power change off frame");
  AST_SHIFT_BLANK: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $changed(o_shift_x) |-> $past(blank)) else $error("shift changed outside blank");
  AST_FAULT_STICKY: assert property (@(posedge i_clk) disable iff (!i_resetn)
    fault != RES_ENOERR |=> $stable(fault)) else $error("fault cleared");
  AST_RANGE: assert property (@(posedge i_clk) disable iff (!i_resetn)
    cmd_go && opcode == OP_SHIFT && !shift_ok |=> status == RES_ERANGE && !$rose(shift_pend))
    else $error("bad shift accepted");
  AST_WIDTH_LOCK: assert property (@(posedge i_clk) disable iff (!i_resetn)
    cmd_go && opcode == OP_BM_WRITE && attr == ATTR_WIDTH |=> status != RES_ENOERR)
    else $error("width changed");
  AST_ONE_PER_FRAME: assert property (@(posedge i_clk) disable iff (!i_resetn)
    cmd_go && opcode == OP_BM_WRITE && frame_used && i_buf_shown[bi] && attr_ok && bidx_ok
    && i_buf_loaded[bi] && attr != ATTR_WIDTH |=> status != RES_ENOERR)
    else $error("second shown update taken");
  AST_STATE_RESP: assert property (@(posedge i_clk) disable iff (!i_resetn)
    cmd_go && opcode == OP_STATE |=> status == RES_ENOERR && resp[23:8] == 16'h0)
    else $error("state response wrong");
  AST_ONE_CMD: assert property (@(posedge i_clk) disable iff (!i_resetn)
    cmd_go |-> ##1 status != RES_PENDING) else $error("command not finished");
  COV_POWER: cover property (@(posedge i_clk) cmd_go && opcode == OP_POWER ##[1:200] fs_rise);
  COV_SHIFT: cover property (@(posedge i_clk) shift_pend ##1 !shift_pend);
  COV_BUSY: cover property (@(posedge i_clk) cmd_go ##1 status == RES_EBUSY);
endmodule : ovl_cmd_handler

/* File: dv/ovl_video_model.sv */
// Video timing and overlay buffer model that faces the command handler.
// Assumes one clock; the bench sets the buffer levels and the fault code.
`timescale 1ns/1ps
module ovl_video_model #(
  parameter int FRAME = 200,
  parameter int BLANK = 20
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_resetn,
  // Levels set by the bench.
  input wire logic [6:0] i_loaded,
  input wire logic [6:0] i_shown,
  input wire logic [7:0] i_fault,
  // Pins seen by the handler.
  output logic o_frame_start,
  output logic o_blank,
  output logic [6:0] o_buf_loaded,
  output logic [6:0] o_buf_shown,
  output logic [7:0] o_fault_code
);
  // ----------------------------------------
  // Frame counter.
  // ----------------------------------------
  int cnt;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt <= 0;
    end else begin
      cnt <= (cnt == FRAME - 1) ? 0 : cnt + 1;
    end
  end
  // Blanking closes each frame, so an update made early in a frame must wait for it.
  assign o_frame_start = i_resetn && (cnt < 4);
  assign o_blank = cnt >= FRAME - BLANK;
  assign o_buf_loaded = i_loaded;
  assign o_buf_shown = i_shown;
  assign o_fault_code = i_fault;
endmodule : ovl_video_model

/* File: dv/ovl_cmd_handler_tb.sv */
// Self-checking bench for the overlay command handler.
// Assumes the video model supplies the timing pins and buffer levels.
`timescale 1ns/1ps
module ovl_cmd_handler_tb;
  import ovl_cmd_pkg::*;
  // ----------------------------------------
  // Stimulus, wiring and monitors.
  // ----------------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wrs = 1'b0;
  logic rds = 1'b0;
  logic [6:0] loaded = 7'h1e;
  logic [6:0] shown = 7'h0c;
  logic [7:0] fault = 8'h00;
  logic fs, blank, on, twr;
  logic [6:0] bl, bs, apply, expd;
  logic [7:0] fc, sx, sy, tattr, cattr;
  logic [1:0] tsel, csel;
  logic [15:0] tval, cval;
  logic [31:0] rdata;
  int expn = 0;
  int errors = 0;
  int checked = 0;
  localparam logic [31:0] EP [4] = '{32'h00000201, 32'h00003301, 32'h00000500, 32'h00000501};
  localparam logic [31:0] EV [4] = '{32'h1, 32'h1, 32'h1, 32'h2};
  localparam logic [7:0] EE [4] = '{RES_EACCES, RES_EINVAL, RES_ENOENT, RES_ERANGE};
  localparam logic [15:0] TOPS [4] = '{OP_TEXT0, OP_TEXT1, OP_TEXT2, OP_TEXT3};
  always #2.5 clk = ~clk;
  ovl_video_model video (.i_clk(clk), .i_resetn(rstn), .i_loaded(loaded), .i_shown(shown),
    .i_fault(fault), .o_frame_start(fs), .o_blank(blank), .o_buf_loaded(bl),
    .o_buf_shown(bs), .o_fault_code(fc));
  ovl_cmd_handler uut (.i_clk(clk), .i_resetn(rstn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wrs), .i_rd(rds), .o_rdata(rdata), .i_frame_start(fs), .i_blank(blank),
    .i_fault_code(fc), .i_buf_loaded(bl), .i_buf_shown(bs), .o_overlay_on(on),
    .o_shift_x(sx), .o_shift_y(sy), .o_shift_apply(apply), .o_expired(expd),
    .o_text_wr(twr), .o_text_sel(tsel), .o_text_attr(tattr), .o_text_value(tval));
  // The text strobe lasts one cycle, so its fields are caught here for later compares.
  always @(posedge clk) begin
    if (twr === 1'b1) begin
      csel <= tsel;
      cattr <= tattr;
      cval <= tval;
    end
    if (expd[1] === 1'b1) expn <= expn + 1;
  end
  // ----------------------------------------
  // Register port, check and frame/blanking wait tasks.
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wrs <= 1'b1;
    @(posedge clk);
    wrs <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rds <= 1'b1;
    @(posedge clk);
    rds <= 1'b0;
    #1 v = rdata;
  endtask : rd
  task automatic cmd(input logic [15:0] op, input logic [31:0] p0, input logic [31:0] p1,
                     input logic [7:0] e);
    logic [31:0] v;
    wr(REG_PARAM, p0);
    wr(4'h2, p1);
    wr(REG_OPCODE, {16'h0, op});
    rd(REG_STATUS, v);
    chk({24'h0, v[7:0]}, {24'h0, e});
  endtask : cmd
  task automatic rsp(input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    rd(REG_RESP, v);
    chk(v & m, e);
  endtask : rsp
  task automatic frm;
    @(posedge fs);
    repeat (8) @(posedge clk);
  endtask : frm
  task automatic blk;
    @(posedge blank);
    repeat (6) @(posedge clk);
  endtask : blk
  task automatic close_out;
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // ----------------------------------------
  // Tests.
  // ----------------------------------------
  initial begin
    logic [31:0] v;
    int n;
    int b;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    cmd(OP_STATE, 32'hffffffff, 32'hffffffff, RES_ENOERR);
    rsp(32'hffffffff, 32'h0);
    frm;
    cmd(OP_POWER, 32'hffffff01, 32'h0, RES_ENOERR);
    cmd(OP_POWER, 32'h00000001, 32'h0, RES_EBUSY);
    chk({31'h0, on}, 32'h0);
    @(posedge fs);
    repeat (6) @(posedge clk);
    chk({31'h0, on}, 32'h1);
    cmd(OP_POWER, 32'h00000001, 32'h0, RES_EALREADY);
    cmd(OP_STATE, 32'h0, 32'h0, RES_ENOERR);
    rsp(32'hffffffff, 32'h1);
    cmd(OP_SHIFT, 32'h00000203, 32'h0, RES_ENOERR);
    chk({16'h0, sy, sx}, 32'h0);
    blk;
    chk({16'h0, sy, sx}, 32'h0203);
    cmd(OP_SHIFT, {16'h0, SHIFT_MAX_DEFAULT + 8'h01, 8'h05}, 32'h0, RES_ERANGE);
    cmd(OP_SHIFT, {16'h0, 8'h01, SHIFT_MAX_DEFAULT + 8'h01}, 32'h0, RES_ERANGE);
    blk;
    chk({16'h0, sy, sx}, 32'h0203);
    rd(REG_SHIFT_OUT, v);
    chk({16'h0, v[15:0]}, 32'h0203);
    frm;
    cmd(OP_BM_WRITE, 32'hffff0502, 32'h1, RES_ENOERR);
    cmd(OP_BM_WRITE, 32'h00000503, 32'h1, RES_EBUSY);
    chk({25'h0, apply}, 32'h0);
    cmd(OP_BM_WRITE, 32'h00000501, 32'h1, RES_ENOERR);
    cmd(OP_BM_WRITE, 32'h00000504, 32'h1, RES_ENOERR);
    chk({25'h0, apply}, 32'h12);
    for (int i = 0; i < 4; i++) cmd(OP_BM_WRITE, EP[i], EV[i], EE[i]);
    blk;
    chk({25'h0, apply}, 32'h16);
    cmd(OP_BM_READ, 32'h00000501, 32'h0, RES_ENOERR);
    rsp(32'hff, 32'h1);
    cmd(OP_BM_READ, 32'h00003301, 32'h0, RES_EINVAL);
    cmd(OP_BM_READ, 32'h00000500, 32'h0, RES_ENOENT);
    frm;
    cmd(OP_BM_WRITE, 32'h00000f01, 32'h1, RES_ENOERR);
    cmd(OP_BM_READ, 32'h00000f01, 32'h0, RES_ENOERR);
    rsp(32'hff, 32'h5);
    n = 0;
    b = expn;
    while (expn == b && n < 8) begin
      @(posedge fs);
      repeat (10) @(posedge clk);
      n++;
    end
    chk(32'(n), 32'h5);
    for (int i = 0; i < 4; i++) begin
      cmd(TOPS[i], {24'hffffff, 8'h10 + 8'(i)}, {16'hdead, 16'ha5a0 + 16'(i)}, RES_ENOERR);
      chk({6'h0, csel, cattr, cval}, {6'h0, 2'(i), 8'h10 + 8'(i), 16'ha5a0 + 16'(i)});
    end
    cmd(OP_TEXT0, 32'h00000033, 32'h0, RES_EINVAL);
    cmd(16'h8210, 32'h0, 32'h0, RES_EINVAL);
    @(posedge clk) fault <= 8'h05;
    @(posedge clk) fault <= 8'h00;
    repeat (4) @(posedge clk);
    cmd(OP_STATE, 32'h0, 32'h0, RES_ENOERR);
    rsp(32'hff000000, 32'h05000000);
    repeat (20) @(posedge clk);
    cmd(OP_STATE, 32'h0, 32'h0, RES_ENOERR);
    rsp(32'hff000000, 32'h05000000);
    @(posedge clk) rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    cmd(OP_STATE, 32'h0, 32'h0, RES_ENOERR);
    rsp(32'hffffffff, 32'h0);
    chk({31'h0, on}, 32'h0);
    close_out;
  end
  // The run needs about ten frames; a hang is cut off well beyond that.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out;
  end
endmodule : ovl_cmd_handler_tb
